/* rtl/lofc_consts.svh */
/*
 * Constants of the LVDS output format stage: register indices, field
 * positions, reset values and clock lane layout.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef LOFC_CONSTS_SVH
`define LOFC_CONSTS_SVH

// Register indices; byte address is four times the index
`define LOFC_IDX_SOFT_RESET   6'h09
`define LOFC_IDX_POL_FMT      6'h18
`define LOFC_IDX_LEVEL        6'h19
`define LOFC_IDX_LANE_TERM    6'h1a
`define LOFC_IDX_CM_TRIM      6'h1b
`define LOFC_IDX_STATUS       6'h1f

// Field positions
`define LOFC_BIT_SOFT_RESET   0
`define LOFC_BIT_DE_LOW       7
`define LOFC_BIT_HS_LOW       6
`define LOFC_BIT_VS_LOW       5
`define LOFC_BIT_DEPTH        3
`define LOFC_BIT_PACKING      1
`define LOFC_BIT_VOCM         6
`define LOFC_BIT_SWING_LSB    2
`define LOFC_BIT_MIRROR       5
`define LOFC_BIT_TERM         1
`define LOFC_BIT_CM_TRIM_LSB  4
`define LOFC_BIT_BUSY         0

// Reset values
`define LOFC_RST_POL_FMT      8'h70
`define LOFC_RST_LEVEL        8'h04
`define LOFC_RST_LANE_TERM    8'h02
`define LOFC_RST_CM_TRIM      8'h00
`define LOFC_RST_CFG          6'h18

// Fixed clock lane word, two high, three low, then two high bit times
`define LOFC_CLK_PATTERN      7'h63
`define LOFC_CLK_LANE         4
`define LOFC_LANES            5

`endif

/* rtl/lofc_pkg.sv */
/*
 * Types of the LVDS output format stage.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package lofc_pkg;

    // Formatting settings that steer the link domain
    typedef struct packed {
        logic dataEnableActiveLow;
        logic hsyncActiveLow;
        logic vsyncActiveLow;
        logic pixelDepthSelect;
        logic colourPackingSelect;
        logic laneOrderMirror;
    } lofc_cfg_t;

    // Incoming pixel with active-high timing flags
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       de;
        logic       hs;
        logic       vs;
    } lofc_pixel_t;

    // Serializer words: index 0..3 data lanes, 4 the clock lane; mirrored lane order puts the clock lane at index 1
    typedef struct packed {
        logic [4:0][6:0] word;
        logic [4:0]      enable;
    } lofc_lanes_t;

    // Output driver trim
    typedef struct packed {
        logic       commonModeLevelSelect;
        logic [1:0] commonModeTrim;
        logic [1:0] outputSwingSelect;
        logic       terminationSelect;
    } lofc_level_t;

    // Handshake source state
    typedef enum logic [0:0] {
        LOFC_IDLE,
        LOFC_WAIT
    } lofc_xfer_state_t;

endpackage

`default_nettype wire

/* rtl/lofc_cfg_xfer.sv */
/*
 * Carries one settings word from the register clock into the pixel
 * clock with a toggle handshake.
 * Assumes the pixel clock runs while a transfer is outstanding.
 */
`default_nettype none

module lofc_cfg_xfer #(
    parameter int               WIDTH    = 6,
    parameter logic [WIDTH-1:0] DST_INIT = '0
) (
    // Register side
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             srcLoad,
    input  wire logic [WIDTH-1:0] srcData,
    output logic                  srcBusy,
    // Pixel side
    input  wire logic             lvdsClk,
    input  wire logic             linkRst,
    output logic [WIDTH-1:0]      dstData,
    output logic                  dstNew
);

    lofc_pkg::lofc_xfer_state_t stateR;
    logic [WIDTH-1:0]           holdR;
    logic                       reqTogR;
    logic                       ackS1R, ackS2R, ackS3R, ackSeenR;
    logic                       reqS1R, reqS2R, reqS3R, reqSeenR;
    logic                       ackEvt, reqEvt;

    // An edge counts once the last two stages agree
    assign ackEvt  = (ackS2R == ackS3R) && (ackS3R != ackSeenR);
    assign reqEvt  = (reqS2R == reqS3R) && (reqS3R != reqSeenR);
    assign srcBusy = (stateR == lofc_pkg::LOFC_WAIT);

    // Source: hold word stable until the far side acknowledges
    always_ff @(posedge mclk) begin
        if (rst) begin
            stateR   <= lofc_pkg::LOFC_IDLE;
            holdR    <= DST_INIT;
            reqTogR  <= 1'b0;
            ackSeenR <= 1'b0;
        end else if (ce) begin
            case (stateR)
                lofc_pkg::LOFC_IDLE: begin
                    if (srcLoad) begin
                        holdR   <= srcData;
                        reqTogR <= ~reqTogR;
                        stateR  <= lofc_pkg::LOFC_WAIT;
                    end
                end
                lofc_pkg::LOFC_WAIT: begin
                    if (ackEvt) begin
                        ackSeenR <= ackS3R;
                        stateR   <= lofc_pkg::LOFC_IDLE;
                    end
                end
                default: stateR <= lofc_pkg::LOFC_IDLE;
            endcase
        end
    end

    // Acknowledge toggle brought back into the register clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            ackS1R <= 1'b0;
            ackS2R <= 1'b0;
            ackS3R <= 1'b0;
        end else if (ce) begin
            ackS1R <= reqSeenR;
            ackS2R <= ackS1R;
            ackS3R <= ackS2R;
        end
    end

    // Destination: take the held word, echo the toggle as acknowledge
    always_ff @(posedge lvdsClk) begin
        if (linkRst) begin
            reqS1R   <= 1'b0;
            reqS2R   <= 1'b0;
            reqS3R   <= 1'b0;
            reqSeenR <= 1'b0;
            dstData  <= DST_INIT;
            dstNew   <= 1'b0;
        end else begin
            reqS1R <= reqTogR;
            reqS2R <= reqS1R;
            reqS3R <= reqS2R;
            dstNew <= reqEvt;
            if (reqEvt) begin
                reqSeenR <= reqS3R;
                dstData  <= holdR; // Stable since the toggle
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/lofc_top.sv */
/*
 * LVDS output format stage: polarity, pixel depth, colour packing,
 * lane order and driver trim, set over an Avalon-MM slave.
 * Assumes pixels arrive on lvdsClk from logic on that clock and the
 * serializer words leave on the same clock; rst is on mclk.
 */
`default_nettype none

`include "lofc_consts.svh"

module lofc_top #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                ce,
    // Avalon-MM slave, byte address
    input  wire logic [ADDR_W-1:0]   avsAddress,
    input  wire logic                avsRead,
    input  wire logic                avsWrite,
    input  wire logic [31:0]         avsWritedata,
    input  wire logic [3:0]          avsByteenable,
    output logic      [31:0]         avsReaddata,
    output logic                     avsWaitrequest,
    // Pixel clock domain
    input  wire logic                lvdsClk,
    input  wire lofc_pkg::lofc_pixel_t pixIn,
    output lofc_pkg::lofc_lanes_t    lanesOut,
    // Output driver trim
    output lofc_pkg::lofc_level_t    levelOut
);

    // Register state on mclk
    logic [7:0]              polFmtR;
    logic [7:0]              levelR;
    logic [7:0]              laneTermR;
    logic [7:0]              cmTrimR;
    logic                    ackR;
    logic                    softPendR;
    logic [31:0]             readdataR;

    // Bus decode
    logic                    busReq;
    logic                    wrTake;
    logic [5:0]              regIdx;
    logic                    wrLow;
    logic [7:0]              wrByte;
    logic [7:0]              rdByte;

    // Crossing
    lofc_pkg::lofc_cfg_t     shadowCfg;
    logic [5:0]              linkCfgBits;
    logic                    linkCfgNew;
    logic                    xferBusy;
    logic                    xferLoad;

    // Link reset synchroniser
    logic                    rstS1R, rstS2R, rstS3R;
    logic                    linkRstR;

    // Link domain state
    lofc_pkg::lofc_cfg_t     pendCfgR;
    logic                    pendValidR;
    lofc_pkg::lofc_cfg_t     activeCfgR;
    lofc_pkg::lofc_cfg_t     curCfg;

    // Formatting
    logic [5:0]              redSix, greenSix, blueSix;
    logic [1:0]              redTwo, greenTwo, blueTwo;
    logic                    deOut, hsOut, vsOut;
    logic [4:0][6:0]         natWord;
    logic [4:0]              natEnable;

    // Six bits per colour for the three base lanes
    function automatic logic [5:0] baseSix(input logic [7:0] c,
                                           input logic       dropLsb);
        baseSix = dropLsb ? c[7:2] : c[5:0];
    endfunction

    // Two bits per colour for the fourth lane
    function automatic logic [1:0] extraTwo(input logic [7:0] c,
                                            input logic       lsbOut);
        extraTwo = lsbOut ? c[1:0] : c[7:6];
    endfunction

    // Which natural lane feeds output lane i
    function automatic int srcLane(input int i, input logic mirror);
        srcLane = i;
        if (mirror) begin
            case (i)
                0:       srcLane = 3;
                1:       srcLane = `LOFC_CLK_LANE;
                3:       srcLane = 0;
                4:       srcLane = 1;
                default: srcLane = i;
            endcase
        end
    endfunction

    // Request decode; writes need the low byte lane
    assign busReq = avsRead | avsWrite;
    assign regIdx = avsAddress[ADDR_W-1:2];
    assign wrLow  = avsByteenable[0];
    assign wrByte = avsWritedata[7:0];
    assign wrTake = avsWrite & ackR & ce & wrLow;

    // One wait cycle, then answer
    assign avsWaitrequest = busReq & ~ackR;
    assign avsReaddata    = readdataR;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ackR <= 1'b0;
        end else if (ce) begin
            ackR <= busReq & ~ackR;
        end
    end

    // Read mux; unmapped indices answer zero
    always_comb begin
        rdByte = 8'h00;
        case (regIdx)
            `LOFC_IDX_POL_FMT:   rdByte = polFmtR;
            `LOFC_IDX_LEVEL:     rdByte = levelR;
            `LOFC_IDX_LANE_TERM: rdByte = laneTermR;
            `LOFC_IDX_CM_TRIM:   rdByte = cmTrimR;
            `LOFC_IDX_STATUS:    rdByte = {7'h00, xferBusy | softPendR};
            default:             rdByte = 8'h00; // Soft reset reads zero
        endcase
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge mclk) begin
        if (rst) begin
            readdataR <= 32'h0000_0000;
        end else if (ce && avsRead && !ackR) begin
            readdataR <= {24'h00_0000, rdByte};
        end
    end

    // Polarity and format register; reserved bit stored as written
    always_ff @(posedge mclk) begin
        if (rst) begin
            polFmtR <= `LOFC_RST_POL_FMT;
        end else if (wrTake && regIdx == `LOFC_IDX_POL_FMT) begin
            polFmtR <= wrByte & 8'hfa;
        end
    end

    // Level select register: common mode and swing
    always_ff @(posedge mclk) begin
        if (rst) begin
            levelR <= `LOFC_RST_LEVEL;
        end else if (wrTake && regIdx == `LOFC_IDX_LEVEL) begin
            levelR <= wrByte & 8'h4c;
        end
    end

    // Lane order and termination register
    always_ff @(posedge mclk) begin
        if (rst) begin
            laneTermR <= `LOFC_RST_LANE_TERM;
        end else if (wrTake && regIdx == `LOFC_IDX_LANE_TERM) begin
            laneTermR <= wrByte & 8'h22;
        end
    end

    // Common-mode trim register
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmTrimR <= `LOFC_RST_CM_TRIM;
        end else if (wrTake && regIdx == `LOFC_IDX_CM_TRIM) begin
            cmTrimR <= wrByte & 8'h30;
        end
    end

    // Driver trim follows the registers one mclk later; no sequencing of the
    // trim against the level is enforced here
    always_ff @(posedge mclk) begin
        if (rst) begin
            levelOut <= '0;
            levelOut.outputSwingSelect <=
                2'(`LOFC_RST_LEVEL >> `LOFC_BIT_SWING_LSB);
            levelOut.terminationSelect <=
                1'(`LOFC_RST_LANE_TERM >> `LOFC_BIT_TERM);
        end else if (ce) begin
            levelOut.commonModeLevelSelect <= levelR[`LOFC_BIT_VOCM];
            levelOut.commonModeTrim <=
                cmTrimR[`LOFC_BIT_CM_TRIM_LSB +: 2];
            levelOut.outputSwingSelect <=
                levelR[`LOFC_BIT_SWING_LSB +: 2];
            levelOut.terminationSelect <= laneTermR[`LOFC_BIT_TERM];
        end
    end

    // Soft reset: self-clearing request; a new write wins over the
    // clear so a request landing during a load is not lost
    assign xferLoad = softPendR & ~xferBusy;

    always_ff @(posedge mclk) begin
        if (rst) begin
            softPendR <= 1'b0;
        end else if (ce) begin
            if (wrTake && regIdx == `LOFC_IDX_SOFT_RESET &&
                wrByte[`LOFC_BIT_SOFT_RESET]) begin
                softPendR <= 1'b1;
            end else if (xferLoad) begin
                softPendR <= 1'b0;
            end
        end
    end

    // Settings gathered for the pixel clock
    always_comb begin
        shadowCfg.dataEnableActiveLow = polFmtR[`LOFC_BIT_DE_LOW];
        shadowCfg.hsyncActiveLow      = polFmtR[`LOFC_BIT_HS_LOW];
        shadowCfg.vsyncActiveLow      = polFmtR[`LOFC_BIT_VS_LOW];
        shadowCfg.pixelDepthSelect    = polFmtR[`LOFC_BIT_DEPTH];
        shadowCfg.colourPackingSelect = polFmtR[`LOFC_BIT_PACKING];
        shadowCfg.laneOrderMirror     = laneTermR[`LOFC_BIT_MIRROR];
    end

    // Word crossing by handshake
    lofc_cfg_xfer #(
        .WIDTH    (6),
        .DST_INIT (`LOFC_RST_CFG)
    ) uXfer (
        .mclk     (mclk),
        .rst      (rst),
        .ce       (ce),
        .srcLoad  (xferLoad),
        .srcData  (shadowCfg),
        .srcBusy  (xferBusy),
        .lvdsClk  (lvdsClk),
        .linkRst  (linkRstR),
        .dstData  (linkCfgBits),
        .dstNew   (linkCfgNew)
    );

    // Reset brought into the pixel clock; takes effect when the last
    // two stages agree, so rst must outlast two pixel clocks
    always_ff @(posedge lvdsClk) begin
        rstS1R <= rst;
        rstS2R <= rstS1R;
        rstS3R <= rstS2R;
        if (rstS2R == rstS3R) begin
            linkRstR <= rstS3R;
        end
    end

    // New settings wait until vertical sync so a frame never changes
    // format midway; a fresh word wins over the clear
    always_ff @(posedge lvdsClk) begin
        if (linkRstR) begin
            pendCfgR   <= `LOFC_RST_CFG;
            pendValidR <= 1'b0;
        end else if (linkCfgNew) begin
            pendCfgR   <= linkCfgBits;
            pendValidR <= 1'b1;
        end else if (pixIn.vs) begin
            pendValidR <= 1'b0;
        end
    end

    // Active settings, swapped only in vertical sync
    always_ff @(posedge lvdsClk) begin
        if (linkRstR) begin
            activeCfgR <= `LOFC_RST_CFG;
        end else if (pendValidR && pixIn.vs) begin
            activeCfgR <= pendCfgR;
        end
    end

    assign curCfg = activeCfgR;

    // Polarity of the timing flags
    assign deOut = pixIn.de ^ curCfg.dataEnableActiveLow;
    assign hsOut = pixIn.hs ^ curCfg.hsyncActiveLow;
    assign vsOut = pixIn.vs ^ curCfg.vsyncActiveLow;

    // Colour split; base lanes take the low six bits per colour, or the high six when colourPackingSelect is set
    always_comb begin
        redSix   = baseSix(pixIn.red,   curCfg.colourPackingSelect);
        greenSix = baseSix(pixIn.green, curCfg.colourPackingSelect);
        blueSix  = baseSix(pixIn.blue,  curCfg.colourPackingSelect);
        redTwo   = extraTwo(pixIn.red,   curCfg.colourPackingSelect);
        greenTwo = extraTwo(pixIn.green, curCfg.colourPackingSelect);
        blueTwo  = extraTwo(pixIn.blue,  curCfg.colourPackingSelect);
    end

    // Lane words in natural order
    always_comb begin
        natWord[0] = {greenSix[0], redSix};
        natWord[1] = {blueSix[1:0], greenSix[5:1]};
        natWord[2] = {deOut, vsOut, hsOut, blueSix[5:2]};
        natWord[3] = 7'h00;
        if (curCfg.pixelDepthSelect) begin
            natWord[3] = {1'b0, blueTwo, greenTwo, redTwo};
        end
        natWord[`LOFC_CLK_LANE] = `LOFC_CLK_PATTERN;
        natEnable = {1'b1, curCfg.pixelDepthSelect, 3'b111};
    end

    // Per-lane output register with optional mirroring
    genvar gi;
    generate
        for (gi = 0; gi < `LOFC_LANES; gi++) begin : gLane
            always_ff @(posedge lvdsClk) begin
                if (linkRstR) begin
                    lanesOut.word[gi]   <= 7'h00;
                    lanesOut.enable[gi] <= 1'b0;
                end else begin
                    lanesOut.word[gi] <=
                        natWord[srcLane(gi, curCfg.laneOrderMirror)];
                    lanesOut.enable[gi] <=
                        natEnable[srcLane(gi, curCfg.laneOrderMirror)];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* tb/lofc_top_props.sv */
/* Port checker of the LVDS output format stage.
   Assumes it is bound onto lofc_top and sees only its ports. */
`default_nettype none
`include "lofc_consts.svh"
module lofc_top_props #(
    parameter int ADDR_W = 8
) (
    // Register side
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire logic [ADDR_W-1:0]     avsAddress,
    input wire logic                  avsRead,
    input wire logic                  avsWrite,
    input wire logic [31:0]           avsWritedata,
    input wire logic [3:0]            avsByteenable,
    input wire logic [31:0]           avsReaddata,
    input wire logic                  avsWaitrequest,
    // Pixel side
    input wire logic                  lvdsClk,
    input wire lofc_pkg::lofc_pixel_t pixIn,
    input wire lofc_pkg::lofc_lanes_t lanesOut,
    input wire lofc_pkg::lofc_level_t levelOut
);
    // Bus answers after exactly one wait cycle
    wait_one_a: assert property (@(posedge mclk) disable iff (rst)
        (avsRead || avsWrite) && avsWaitrequest && ce |=> !avsWaitrequest)
        else $error("request not answered after one wait cycle");
    idle_ready_a: assert property (@(posedge mclk) disable iff (rst)
        !avsRead && !avsWrite |-> !avsWaitrequest)
        else $error("wait asserted with no request");
    read_upper_a: assert property (@(posedge mclk) disable iff (rst)
        avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0)
        else $error("upper read data not zero");
    // Driver trim leaves reset at its reset values
    level_reset_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> levelOut == 6'h03)
        else $error("driver trim reset value wrong");
    level_cause_a: assert property (@(posedge mclk) disable iff (rst)
        $changed(levelOut) |-> $past(avsWrite) || $past(avsWrite, 2))
        else $error("driver trim changed without a write");
    // Lane shape holds whatever the settings
    clock_lane_a: assert property (@(posedge lvdsClk) disable iff (rst)
        lanesOut.enable[2] |-> lanesOut.word[4] == `LOFC_CLK_PATTERN
            || lanesOut.word[1] == `LOFC_CLK_PATTERN)
        else $error("clock lane pattern missing");
    lane_off_a: assert property (@(posedge lvdsClk) disable iff (rst)
        lanesOut.enable[2] |-> (lanesOut.enable[0] || lanesOut.word[0] == 7'h0)
            && (lanesOut.enable[3] || lanesOut.word[3] == 7'h0))
        else $error("disabled lane carries data");
    lane_enable_a: assert property (@(posedge lvdsClk) disable iff (rst)
        lanesOut.enable[2] |-> lanesOut.enable[1] && lanesOut.enable[4]
            && (lanesOut.enable[0] || lanesOut.enable[3]))
        else $error("lane enables inconsistent");
    // Settings change only right after a frame sync
    frame_apply_a: assert property (@(posedge lvdsClk) disable iff (rst)
        $changed(lanesOut.enable) && $past(lanesOut.enable[2])
            |-> $past(pixIn.vs, 2))
        else $error("lane settings changed away from frame sync");
endmodule
bind lofc_top lofc_top_props #(.ADDR_W(ADDR_W)) lofc_top_props_i (
    .mclk(mclk), .rst(rst), .ce(ce), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .lvdsClk(lvdsClk), .pixIn(pixIn),
    .lanesOut(lanesOut), .levelOut(levelOut));
`default_nettype wire

/* tb/lofc_panel_rx.sv */
/* Flat panel receiver model: restores lane order, rebuilds pixels.
   Assumes its strap matches the settings applied in the stage. */
`default_nettype none
module lofc_panel_rx (
    // Link from the stage
    input  wire lofc_pkg::lofc_lanes_t lanes,
    // Panel strapping
    input  wire lofc_pkg::lofc_cfg_t   strap,
    // Recovered pixel, flags at line level
    output lofc_pkg::lofc_pixel_t      pix,
    output logic                       fourthOn
);
    logic       m;
    logic       p;
    logic [6:0] l0, l1, l2, l3;
    logic [5:0] two;
    // Undo the mirrored order
    always_comb begin
        m = strap.laneOrderMirror;
        l0 = m ? lanes.word[3] : lanes.word[0];
        l1 = m ? lanes.word[4] : lanes.word[1];
        l2 = lanes.word[2];
        l3 = m ? lanes.word[0] : lanes.word[3];
        fourthOn = m ? lanes.enable[0] : lanes.enable[3];
    end
    // An 18-bit panel never looks at the fourth lane
    always_comb begin
        p = strap.colourPackingSelect;
        two = strap.pixelDepthSelect ? l3[5:0] : 6'h0;
        pix.red = p ? {l0[5:0], two[1:0]} : {two[1:0], l0[5:0]};
        pix.green = p ? {l1[4:0], l0[6], two[3:2]}
                      : {two[3:2], l1[4:0], l0[6]};
        pix.blue = p ? {l2[3:0], l1[6:5], two[5:4]}
                     : {two[5:4], l2[3:0], l1[6:5]};
        pix.de = l2[6];
        pix.vs = l2[5];
        pix.hs = l2[4];
    end
endmodule
`default_nettype wire

/* tb/lofc_top_bench.sv */
/* Self-checking bench of the LVDS output format stage.
   Assumes a receiver model strapped to the expected settings. */
`default_nettype none
module lofc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  mclk = 1'b0, lvdsClk = 1'b0, rst = 1'b1;
    logic                  ce = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
    logic [7:0]            avsAddress = 8'h0, cnt = 8'h0;
    logic [31:0]           avsWritedata = 32'h0, avsReaddata;
    logic [3:0]            avsByteenable = 4'h0;
    logic                  avsWaitrequest, chkOn = 1'b0, fourthOn;
    lofc_pkg::lofc_pixel_t pixIn = '0, pixSent = '0, rxPix;
    lofc_pkg::lofc_lanes_t lanesOut;
    lofc_pkg::lofc_level_t levelOut;
    lofc_pkg::lofc_cfg_t   expCfg = 6'h18;
    int                    n_fail = 0, num_checks = 0;

    // Unrelated clock rates
    always #5 mclk = ~mclk;
    always #6 lvdsClk = ~lvdsClk;

    lofc_top #(.ADDR_W(8)) lofc_top_i (.mclk(mclk), .rst(rst), .ce(ce),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .lvdsClk(lvdsClk), .pixIn(pixIn), .lanesOut(lanesOut),
        .levelOut(levelOut));
    lofc_panel_rx lofc_panel_rx_i (.lanes(lanesOut), .strap(expCfg),
        .pix(rxPix), .fourthOn(fourthOn));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd, input logic [3:0] be,
                       output logic [7:0] rdat);
        int i;
        i = 0;
        @(posedge mclk);
        avsAddress <= {idx, 2'b00};
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= {24'h0, wd};
        avsByteenable <= be;
        do begin
            @(posedge mclk);
            i++;
        end while (avsWaitrequest !== 1'b0 && i < 20);
        rdat = avsReaddata[7:0];
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (i >= 20) begin
            n_fail++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, 4'hf, d);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, idx, 8'h0, 4'hf, d);
        check("readdata", exp, d);
    endtask

    // Old settings must hold until the soft reset is written; new ones are checked after it lands
    task automatic apply(input logic [7:0] fmt, input logic [7:0] lane);
        logic [7:0] d;
        int i;
        wr(6'h18, fmt);
        wr(6'h1a, lane);
        repeat (40) @(posedge lvdsClk);
        chkOn = 1'b0;
        wr(6'h09, 8'h01);
        for (i = 0; i < 50; i++) begin
            bus(1'b0, 6'h1f, 8'h0, 4'hf, d);
            if (d[0] === 1'b0) break;
        end
        if (i >= 50) begin
            n_fail++;
            finish_test();
        end
        repeat (70) @(posedge lvdsClk);
        expCfg = '{fmt[7], fmt[6], fmt[5], fmt[3], fmt[1], lane[5]};
        chkOn = 1'b1;
        repeat (70) @(posedge lvdsClk);
    endtask

    function automatic logic [7:0] col(input logic [7:0] c);
        if (expCfg.pixelDepthSelect) return c;
        return expCfg.colourPackingSelect ? {c[7:2], 2'h0} : {2'h0, c[5:0]};
    endfunction

    // Frames of 32 pixels with a two-pixel sync at the start
    always @(posedge lvdsClk) begin
        cnt <= cnt + 8'h1;
        pixSent <= pixIn;
        pixIn <= '{red: cnt * 8'h25, green: ~cnt ^ 8'h5a,
                   blue: cnt * 8'h13 + 8'h07, de: cnt[4:0] > 5'h07,
                   hs: cnt[2:0] == 3'h3, vs: cnt[4:0] < 5'h02};
    end

    // Recovered pixel against the one sent an edge earlier
    always @(negedge lvdsClk) begin
        if (chkOn) begin
            check("red", col(pixSent.red), rxPix.red);
            check("green", col(pixSent.green), rxPix.green);
            check("blue", col(pixSent.blue), rxPix.blue);
            check("de", 8'(pixSent.de ^ expCfg.dataEnableActiveLow),
                  8'(rxPix.de));
            check("hs", 8'(pixSent.hs ^ expCfg.hsyncActiveLow),
                  8'(rxPix.hs));
            check("vs", 8'(pixSent.vs ^ expCfg.vsyncActiveLow),
                  8'(rxPix.vs));
            check("fourth", 8'(expCfg.pixelDepthSelect), 8'(fourthOn));
        end
    end

    initial begin
        int i;
        logic [7:0] d;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 100 && lanesOut.enable[2] !== 1'b1; i++) begin
            @(posedge lvdsClk);
        end
        if (i >= 100) begin
            n_fail++;
            finish_test();
        end
        repeat (2) @(posedge lvdsClk);
        chkOn = 1'b1;
        // Reset values and the write-only soft reset place
        rd(6'h18, 8'h70);
        rd(6'h19, 8'h04);
        rd(6'h1a, 8'h02);
        rd(6'h1b, 8'h00);
        rd(6'h09, 8'h00);
        check("level", 8'h03, 8'(levelOut));
        // Trim first, then the lower common mode
        wr(6'h1b, 8'h1f);
        rd(6'h1b, 8'h10);
        wr(6'h19, 8'hff);
        rd(6'h19, 8'h4c);
        bus(1'b1, 6'h1b, 8'h00, 4'he, d);
        rd(6'h1b, 8'h10);
        wr(6'h30, 8'hff);
        rd(6'h30, 8'h00);
        check("level", 8'h2f, 8'(levelOut));
        // Settings sweep; bit 4 always written as one, input is 24-bit
        apply(8'hf8, 8'h00);
        check("level", 8'h2e, 8'(levelOut));
        apply(8'h1a, 8'h22);
        apply(8'h92, 8'h20);
        apply(8'h30, 8'h02);
        rd(6'h18, 8'h30);
        finish_test();
    end
endmodule
`default_nettype wire
